// *** mbp_front_end.sv ***
// video_front_end end: parses inline dwords of one command, keeps the
// fields it consumes and packs the payload into thread registers.
// Assumes a well formed stream with last on the final dword.
// Behaviour
// - Motion vector size codes vector count
// - Intra source writes zero vector size
// - DC coded flags consumed, not forwarded
// - Transform bit selects 8x8 or 4x4
// - Bit 14 marks field macroblock
// - Bit 13 marks intra macroblock
// - Bits 7:6 give bidirectional weighting mode
// - P source keeps weighting upper bit zero
// - Intra source zeroes weighting bits
// - Bits 3:2 give chroma sampling format
// - Adaptive bit zero for field picture
// - Bit 0 marks field picture
// - Second dword carries vertical, horizontal origin
// - Third dword gives quantizers and patterns
// - Level scales used, Cb still forwarded
// - Weight block follows motion vector block
// - Residual offset set by state command
// - One macroblock per command
// - Forward inline contiguously, zero fill tail
// - Inline data starts at dword 4
// - VC1 bits 31:28 select reference fields
module mbp_front_end
    import mbp_pkg::*;
#(
    parameter int DWORDS = REG_DWORDS
) (
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    mbp_if.front_end                  cmd,
    input  wire logic [15:0]          residual_offset_i,
    output logic                      reg_write_o,
    output logic [7:0]                reg_index_o,
    output logic [DWORDS*32-1:0]      reg_data_o,
    output logic                      mb_done_o,
    output mbp_mode_t                 mb_mode_o,
    output logic [5:0]                mv_count_o,
    output logic [5:0]                weight_offset_o,
    output logic [15:0]               residual_offset_o,
    output logic [2:0]                dc_coded_o,
    output logic                      luma_block_8x8_o,
    output logic                      field_macroblock_flag_o,
    output logic                      intra_macroblock_flag_o,
    output logic [1:0]                bidirectional_weighting_mode_o,
    output logic                      single_direction_weighting_flag_o,
    output logic [1:0]                chroma_sampling_format_o,
    output logic                      adaptive_frame_field_picture_o,
    output logic                      field_picture_flag_o,
    output logic [7:0]                vertical_origin_o,
    output logic [7:0]                horizontal_origin_o,
    output logic [7:0]                red_chroma_quantizer_o,
    output logic [7:0]                blue_chroma_quantizer_o,
    output logic [7:0]                luma_quantizer_o,
    output logic [3:0]                red_chroma_coded_pattern_o,
    output logic [3:0]                blue_chroma_coded_pattern_o,
    output logic [15:0]               luma_dc_scale_o,
    output logic [15:0]               blue_chroma_dc_scale_o,
    output logic [15:0]               red_chroma_dc_scale_o,
    output logic [3:0]                reference_field_select_o
);
    localparam int SLOT_W = $clog2(DWORDS);

    logic [IDX_W-1:0]        dw_idx;
    logic [SLOT_W-1:0]       slot;
    logic [DWORDS*32-1:0]    pack;
    logic                    take;
    logic                    inline_dw;
    logic [31:0]             fwd_dw;
    logic [DWORDS*32-1:0]    next_pack;

    // ------------------------------------------------------------
    // Stream acceptance
    // ------------------------------------------------------------
    // The register file port never stalls, so ready only waits out reset.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cmd.ready <= 1'b0;
        end else begin
            cmd.ready <= 1'b1;
        end
    end

    assign take      = cmd.valid && cmd.ready;
    assign inline_dw = (dw_idx >= IDX_W'(INLINE_FIRST_DW));

    // Index restarts with each command, so each command is one macroblock
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            dw_idx <= '0;
        end else if (take) begin
            if (cmd.last) begin
                dw_idx <= '0;
            end else if (dw_idx != '1) begin
                dw_idx <= dw_idx + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Payload packing
    // ------------------------------------------------------------
    always_comb begin
        fwd_dw = cmd.data;
        if (cmd.mode == MBP_MODE_AVC && dw_idx == DW_FLAGS) begin
            fwd_dw[DC_Y_BIT:DC_CR_BIT] = 3'h0;
        end
    end

    // Slots above the current one are cleared so a short tail reads zero
    always_comb begin
        next_pack = pack;
        for (int i = 0; i < DWORDS; i++) begin
            if (i == int'(slot)) begin
                next_pack[i*32 +: 32] = fwd_dw;
            end else if (i > int'(slot)) begin
                next_pack[i*32 +: 32] = 32'h0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pack <= '0;
            slot <= '0;
        end else if (take && inline_dw) begin
            pack <= next_pack;
            if (cmd.last || slot == SLOT_W'(DWORDS - 1)) begin
                slot <= '0;
            end else begin
                slot <= slot + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_write_o <= 1'b0;
            reg_data_o  <= '0;
            reg_index_o <= '0;
        end else begin
            reg_write_o <= 1'b0;
            if (take && inline_dw && (cmd.last || slot == SLOT_W'(DWORDS - 1))) begin
                reg_write_o <= 1'b1;
                reg_data_o  <= next_pack;
            end
            if (reg_write_o) begin
                reg_index_o <= mb_done_o ? 8'h00 : reg_index_o + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mb_done_o         <= 1'b0;
            mb_mode_o         <= MBP_MODE_AVC;
            residual_offset_o <= '0;
        end else begin
            mb_done_o <= take && cmd.last;
            if (take && dw_idx == '0) begin
                mb_mode_o         <= cmd.mode;
                residual_offset_o <= residual_offset_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Consumed fields; reserved bits are never inspected
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mv_count_o                        <= '0;
            weight_offset_o                   <= '0;
            dc_coded_o                        <= '0;
            luma_block_8x8_o                  <= 1'b0;
            field_macroblock_flag_o           <= 1'b0;
            intra_macroblock_flag_o           <= 1'b0;
            bidirectional_weighting_mode_o    <= WEIGHT_DEFAULT;
            single_direction_weighting_flag_o <= 1'b0;
            chroma_sampling_format_o          <= CHROMA_MONO;
            adaptive_frame_field_picture_o    <= 1'b0;
            field_picture_flag_o              <= 1'b0;
            reference_field_select_o          <= '0;
        end else if (take && dw_idx == DW_FLAGS) begin
            if (cmd.mode == MBP_MODE_VC1) begin
                reference_field_select_o <= cmd.data[REF_SEL_LSB +: 4];
            end else begin
                // Reserved size codes give no vectors rather than an error
                unique case (cmd.data[MOTION_VECTOR_SIZE_LSB +: 3])
                    MV_ONE_PAIR:      mv_count_o <= MV_CNT_ONE_PAIR;
                    MV_FOUR_PAIRS:    mv_count_o <= MV_CNT_FOUR_PAIRS;
                    MV_SIXTEEN:       mv_count_o <= MV_CNT_SIXTEEN;
                    MV_SIXTEEN_PAIRS: mv_count_o <= MV_CNT_SIXTEEN_PR;
                    default:          mv_count_o <= '0;
                endcase
                unique case (cmd.data[MOTION_VECTOR_SIZE_LSB +: 3])
                    MV_ONE_PAIR:      weight_offset_o <= MV_CNT_ONE_PAIR;
                    MV_FOUR_PAIRS:    weight_offset_o <= MV_CNT_FOUR_PAIRS;
                    MV_SIXTEEN:       weight_offset_o <= MV_CNT_SIXTEEN;
                    MV_SIXTEEN_PAIRS: weight_offset_o <= MV_CNT_SIXTEEN_PR;
                    default:          weight_offset_o <= '0;
                endcase
                dc_coded_o                        <= cmd.data[DC_Y_BIT:DC_CR_BIT];
                luma_block_8x8_o                  <= cmd.data[LARGE_XFORM_BIT];
                field_macroblock_flag_o           <= cmd.data[FIELD_MB_BIT];
                intra_macroblock_flag_o           <= cmd.data[INTRA_BIT];
                bidirectional_weighting_mode_o    <= cmd.data[BIWEIGHT_LSB +: 2];
                single_direction_weighting_flag_o <= cmd.data[SINGLE_WEIGHT_BIT];
                chroma_sampling_format_o          <= cmd.data[CHROMA_LSB +: 2];
                adaptive_frame_field_picture_o    <= cmd.data[ADAPTIVE_BIT];
                field_picture_flag_o              <= cmd.data[FIELD_PIC_BIT];
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            vertical_origin_o           <= '0;
            horizontal_origin_o         <= '0;
            red_chroma_quantizer_o      <= '0;
            blue_chroma_quantizer_o     <= '0;
            luma_quantizer_o            <= '0;
            red_chroma_coded_pattern_o  <= '0;
            blue_chroma_coded_pattern_o <= '0;
            luma_dc_scale_o             <= '0;
            blue_chroma_dc_scale_o      <= '0;
            red_chroma_dc_scale_o       <= '0;
        end else if (take && cmd.mode == MBP_MODE_AVC) begin
            if (dw_idx == DW_ORIGIN) begin
                vertical_origin_o   <= cmd.data[VORIGIN_LSB +: 8];
                horizontal_origin_o <= cmd.data[7:0];
            end
            if (dw_idx == DW_QUANT) begin
                red_chroma_quantizer_o      <= cmd.data[QP_CR_LSB +: 8];
                blue_chroma_quantizer_o     <= cmd.data[QP_CB_LSB +: 8];
                luma_quantizer_o            <= cmd.data[QP_Y_LSB +: 8];
                red_chroma_coded_pattern_o  <= cmd.data[CBP_CR_LSB +: 4];
                blue_chroma_coded_pattern_o <= cmd.data[3:0];
            end
            if (dw_idx == DW_CHROMA_SCALE) begin
                blue_chroma_dc_scale_o <= cmd.data[SCALE_HI_LSB +: 16];
                red_chroma_dc_scale_o  <= cmd.data[15:0];
            end
            if (dw_idx == DW_LUMA_SCALE) begin
                luma_dc_scale_o <= cmd.data[15:0];
            end
        end
    end
endmodule : mbp_front_end

// *** mbp_pkg.sv ***
// Package for the macroblock inline payload parser: field positions,
// dword indices, encodings and the width of one thread register.
// Assumes both ends and the bench import it whole.
package mbp_pkg;
    // ------------------------------------------------------------
    // Command layout
    // ------------------------------------------------------------
    localparam int          INLINE_FIRST_DW   = 4;
    localparam int          REG_DWORDS        = 8;
    localparam int          IDX_W             = 5;
    // Inline dword indices counted from the command start (AVC)
    localparam logic [4:0]  DW_FLAGS          = 5'h04;
    localparam logic [4:0]  DW_ORIGIN         = 5'h05;
    localparam logic [4:0]  DW_QUANT          = 5'h06;
    localparam logic [4:0]  DW_CHROMA_SCALE   = 5'h0A;
    localparam logic [4:0]  DW_LUMA_SCALE     = 5'h0B;
    // ------------------------------------------------------------
    // First inline dword fields
    // ------------------------------------------------------------
    localparam int          MOTION_VECTOR_SIZE_LSB        = 20;
    localparam int          DC_Y_BIT          = 19;
    localparam int          DC_CB_BIT         = 18;
    localparam int          DC_CR_BIT         = 17;
    localparam int          LARGE_XFORM_BIT   = 15;
    localparam int          FIELD_MB_BIT      = 14;
    localparam int          INTRA_BIT         = 13;
    localparam int          BIWEIGHT_LSB      = 6;
    localparam int          SINGLE_WEIGHT_BIT = 5;
    localparam int          CHROMA_LSB        = 2;
    localparam int          ADAPTIVE_BIT      = 1;
    localparam int          FIELD_PIC_BIT     = 0;
    localparam int          REF_SEL_LSB       = 28;
    // Other dword fields
    localparam int          VORIGIN_LSB       = 8;
    localparam int          QP_CR_LSB         = 24;
    localparam int          QP_CB_LSB         = 16;
    localparam int          QP_Y_LSB          = 8;
    localparam int          CBP_CR_LSB        = 4;
    localparam int          SCALE_HI_LSB      = 16;
    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [2:0]  MV_NONE           = 3'h0;
    localparam logic [2:0]  MV_ONE_PAIR       = 3'h2;
    localparam logic [2:0]  MV_FOUR_PAIRS     = 3'h4;
    localparam logic [2:0]  MV_SIXTEEN        = 3'h5;
    localparam logic [2:0]  MV_SIXTEEN_PAIRS  = 3'h6;
    localparam logic [5:0]  MV_CNT_ONE_PAIR   = 6'h02;
    localparam logic [5:0]  MV_CNT_FOUR_PAIRS = 6'h08;
    localparam logic [5:0]  MV_CNT_SIXTEEN    = 6'h10;
    localparam logic [5:0]  MV_CNT_SIXTEEN_PR = 6'h20;
    localparam logic [1:0]  WEIGHT_DEFAULT    = 2'h0;
    localparam logic [1:0]  WEIGHT_EXPLICIT   = 2'h1;
    localparam logic [1:0]  WEIGHT_IMPLICIT   = 2'h2;
    localparam logic [1:0]  CHROMA_MONO       = 2'h0;
    localparam logic [1:0]  CHROMA_420        = 2'h1;

    typedef enum logic {
        MBP_MODE_AVC = 1'b0,
        MBP_MODE_VC1 = 1'b1
    } mbp_mode_t;
endpackage : mbp_pkg

// *** mbp_if.sv ***
// Dword stream of one extended_media_object_command from the command
// source to the video_front_end. Both ends sit on the same clock.
interface mbp_if;
    import mbp_pkg::*;
    logic        valid;
    logic        ready;
    logic [31:0] data;
    logic        last;
    mbp_mode_t   mode;

    modport source (output valid, output data, output last, output mode, input ready);
    modport front_end (input valid, input data, input last, input mode, output ready);
endinterface : mbp_if

// *** mbp_source.sv ***
// Command source end: software loads a command into a small buffer,
// then the source streams it, cleaning the first inline dword of AVC commands.
// Assumes the loaded command is at least five dwords long.
module mbp_source
    import mbp_pkg::*;
#(
    parameter int MAX_DW = 16
) (
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    mbp_if.source                          cmd,
    input  wire logic                      load_i,
    input  wire logic [$clog2(MAX_DW)-1:0] load_addr_i,
    input  wire logic [31:0]               load_data_i,
    input  wire logic [$clog2(MAX_DW)-1:0] last_idx_i,
    input  wire logic                      vc1_mode_i,
    input  wire logic                      p_macroblock_i,
    input  wire logic                      go_i,
    output logic                           busy_o,
    output logic                           done_o
);
    localparam int AW = $clog2(MAX_DW);

    logic [31:0]   mem [MAX_DW];
    logic [AW-1:0] rd_idx;
    logic [AW-1:0] end_idx;
    logic [31:0]   raw;
    logic [31:0]   next_dw;

    always_ff @(posedge clk_i) begin
        if (load_i && !busy_o) begin
            mem[load_addr_i] <= load_data_i;
        end
    end

    assign raw = mem[rd_idx];

    // ------------------------------------------------------------
    // Cleaning of the first inline dword
    // ------------------------------------------------------------
    always_comb begin
        next_dw = raw;
        if (!vc1_mode_i && rd_idx == AW'(INLINE_FIRST_DW)) begin
            if (raw[INTRA_BIT]) begin
                next_dw[MOTION_VECTOR_SIZE_LSB +: 3]    = MV_NONE;
                next_dw[BIWEIGHT_LSB +: 2]  = 2'h0;
                next_dw[SINGLE_WEIGHT_BIT]  = 1'b0;
            end else if (p_macroblock_i) begin
                next_dw[BIWEIGHT_LSB +: 2] = {1'b0, raw[SINGLE_WEIGHT_BIT]};
            end
            if (raw[FIELD_PIC_BIT]) begin
                next_dw[ADAPTIVE_BIT] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Streaming
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
            rd_idx    <= '0;
            end_idx   <= '0;
            cmd.valid <= 1'b0;
            cmd.data  <= 32'h0;
            cmd.last  <= 1'b0;
            cmd.mode  <= MBP_MODE_AVC;
        end else begin
            done_o <= 1'b0;
            if (!busy_o) begin
                if (go_i) begin
                    busy_o   <= 1'b1;
                    rd_idx   <= '0;
                    end_idx  <= last_idx_i;
                    cmd.mode <= vc1_mode_i ? MBP_MODE_VC1 : MBP_MODE_AVC;
                end
            end else if (!cmd.valid || cmd.ready) begin
                if (cmd.valid && cmd.last) begin
                    cmd.valid <= 1'b0;
                    cmd.last  <= 1'b0;
                    busy_o    <= 1'b0;
                    done_o    <= 1'b1;
                end else begin
                    cmd.valid <= 1'b1;
                    cmd.data  <= next_dw;
                    cmd.last  <= (rd_idx == end_idx);
                    rd_idx    <= rd_idx + 1'b1;
                end
            end
        end
    end
endmodule : mbp_source

// *** mbp_asserts.sv ***
// Concurrent checks on the dword stream between the two ends.
// Assumes one clock and the interface signals wired in directly.
module mbp_asserts
    import mbp_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        valid,
    input  wire logic        ready,
    input  wire logic [31:0] data,
    input  wire logic        last,
    input  wire mbp_mode_t   mode
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic [4:0] idx;
    logic [1:0] up_cnt;
    logic       flags_dw;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            idx <= 5'h00;
        end else if (valid && ready) begin
            idx <= last ? 5'h00 : idx + 5'h01;
        end
    end
    // Saturates so the ready check starts once the release edge has passed
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            up_cnt <= 2'h0;
        end else if (up_cnt != 2'h2) begin
            up_cnt <= up_cnt + 2'h1;
        end
    end
    assign flags_dw = valid && (idx == DW_FLAGS) && (mode == MBP_MODE_AVC);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_cmd_end;
        valid && ready && last;
    endsequence
    sequence s_mid_cmd;
        valid && !last;
    endsequence
    property p_intra_no_mv;
        flags_dw && data[INTRA_BIT] |-> data[22:20] == 3'h0;
    endproperty
    property p_intra_no_weight;
        flags_dw && data[INTRA_BIT] |-> data[7:5] == 3'h0;
    endproperty
    property p_field_no_adaptive;
        flags_dw && data[FIELD_PIC_BIT] |-> !data[ADAPTIVE_BIT];
    endproperty
    property p_last_min;
        valid && last |-> idx >= 5'h04;
    endproperty
    property p_mode_stable;
        valid && idx != 5'h00 |-> $stable(mode);
    endproperty
    property p_contiguous;
        s_mid_cmd |=> valid;
    endproperty
    property p_end_gap;
        s_cmd_end |=> !valid;
    endproperty
    property p_never_refuse;
        up_cnt == 2'h2 |-> ready;
    endproperty
    a_intra_no_mv: assert property (p_intra_no_mv)
        else $error("vector size not zero on intra macroblock");
    a_intra_no_weight: assert property (p_intra_no_weight)
        else $error("weighting bits not zero on intra macroblock");
    a_field_no_adaptive: assert property (p_field_no_adaptive)
        else $error("adaptive bit set on field picture");
    a_last_min: assert property (p_last_min)
        else $error("command ended before the first inline dword");
    a_mode_stable: assert property (p_mode_stable)
        else $error("mode changed inside a command");
    a_contiguous: assert property (p_contiguous)
        else $error("gap inside a command");
    a_end_gap: assert property (p_end_gap)
        else $error("valid held after the final dword");
    a_never_refuse: assert property (p_never_refuse)
        else $error("front end refused a dword");
endmodule : mbp_asserts

// *** tb_top.sv ***
// Bench joining source and front end; loads commands, streams them
// and compares parsed fields and packed registers with expectations.
// Assumes default parameters on both ends.
module tb_top;
    import mbp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk_i, reset_i, load_i, vc1_mode_i, p_mb_i, go_i, busy_o, done_o;
    logic [3:0]   load_addr_i, last_idx_i;
    logic [31:0]  load_data_i, d;
    logic [31:0]  cmd_w [16];
    logic [255:0] reg_seen;
    logic [7:0]   idx_seen;
    int           fails, checked, nreg, ndone, i;
    logic [2:0]   mvc [5] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6};
    logic [5:0]   mvn [5] = '{6'h00, 6'h02, 6'h08, 6'h10, 6'h20};
    mbp_if u_if ();
    mbp_source u_mbp_source (.clk_i(clk_i), .reset_i(reset_i), .cmd(u_if), .load_i(load_i),
        .load_addr_i(load_addr_i), .load_data_i(load_data_i), .last_idx_i(last_idx_i),
        .vc1_mode_i(vc1_mode_i), .p_macroblock_i(p_mb_i), .go_i(go_i), .busy_o(busy_o),
        .done_o(done_o));
    mbp_front_end u_mbp_front_end (.clk_i(clk_i), .reset_i(reset_i), .cmd(u_if),
        .residual_offset_i(16'h0140), .reg_write_o(), .reg_index_o(), .reg_data_o(),
        .mb_done_o(), .mb_mode_o(), .mv_count_o(), .weight_offset_o(), .residual_offset_o(),
        .dc_coded_o(), .luma_block_8x8_o(), .field_macroblock_flag_o(),
        .intra_macroblock_flag_o(), .bidirectional_weighting_mode_o(),
        .single_direction_weighting_flag_o(), .chroma_sampling_format_o(),
        .adaptive_frame_field_picture_o(), .field_picture_flag_o(), .vertical_origin_o(),
        .horizontal_origin_o(), .red_chroma_quantizer_o(), .blue_chroma_quantizer_o(),
        .luma_quantizer_o(), .red_chroma_coded_pattern_o(), .blue_chroma_coded_pattern_o(),
        .luma_dc_scale_o(), .blue_chroma_dc_scale_o(), .red_chroma_dc_scale_o(),
        .reference_field_select_o());
    mbp_asserts u_mbp_asserts (.clk_i(clk_i), .reset_i(reset_i), .valid(u_if.valid),
        .ready(u_if.ready), .data(u_if.data), .last(u_if.last), .mode(u_if.mode));
    always #50 clk_i = ~clk_i;
    // Pulses are sampled at the edge that ends them
    always @(posedge clk_i) begin
        if (u_mbp_front_end.reg_write_o === 1'b1) begin
            reg_seen = u_mbp_front_end.reg_data_o;
            idx_seen = u_mbp_front_end.reg_index_o;
            nreg++;
        end
        if (u_mbp_front_end.mb_done_o === 1'b1) begin
            ndone++;
        end
    end
    task automatic check(input string name, input logic [255:0] seen, input logic [255:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    task automatic run_cmd(input int last, input logic vc1, input logic pmb);
        int k;
        for (k = 0; k <= last; k++) begin
            @(posedge clk_i);
            load_i <= 1'b1;
            load_addr_i <= k[3:0];
            load_data_i <= cmd_w[k];
        end
        @(posedge clk_i);
        load_i <= 1'b0;
        last_idx_i <= last[3:0];
        vc1_mode_i <= vc1;
        p_mb_i <= pmb;
        go_i <= 1'b1;
        nreg = 0;
        @(posedge clk_i);
        go_i <= 1'b0;
        k = 0;
        while (k < 60 && done_o !== 1'b1) begin
            @(negedge clk_i);
            k++;
        end
        check("done", {busy_o, done_o}, 2'h1);
        repeat (2) @(posedge clk_i);
    endtask : run_cmd
    task automatic chk_reg(input int last, input logic [31:0] d4);
        logic [255:0] e;
        int k;
        e = '0;
        for (k = last - (last-4)%8; k <= last; k++) e[(k-4)%8*32 +: 32] = k > 4 ? cmd_w[k] : d4;
        check("reg count", nreg, (last-4)/8+1);
        check("reg index", idx_seen, (last-4)/8);
        check("reg data", reg_seen, e);
    endtask : chk_reg
    initial begin
        {clk_i, load_i, vc1_mode_i, p_mb_i, go_i, load_addr_i, last_idx_i, load_data_i} = '0;
        reset_i = 1'b1;
        for (i = 0; i < 16; i++) cmd_w[i] = 32'h9000_0000 + i;
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        cmd_w[4] = 32'h006E_E0E7;
        cmd_w[5] = 32'h1234_5678;
        cmd_w[6] = 32'h1122_3345;
        cmd_w[10] = 32'hBEEF_CAFE;
        cmd_w[11] = 32'h0000_F00D;
        run_cmd(15, 1'b0, 1'b0);
        check("mv count", u_mbp_front_end.mv_count_o, 6'h00);
        check("bi weight", u_mbp_front_end.bidirectional_weighting_mode_o, 2'h0);
        check("one weight", u_mbp_front_end.single_direction_weighting_flag_o, 1'b0);
        check("adaptive", u_mbp_front_end.adaptive_frame_field_picture_o, 1'b0);
        check("field pic", u_mbp_front_end.field_picture_flag_o, 1'b1);
        check("intra", u_mbp_front_end.intra_macroblock_flag_o, 1'b1);
        check("large xform", u_mbp_front_end.luma_block_8x8_o, 1'b1);
        check("field mb", u_mbp_front_end.field_macroblock_flag_o, 1'b1);
        check("chroma", u_mbp_front_end.chroma_sampling_format_o, CHROMA_420);
        check("dc flags", u_mbp_front_end.dc_coded_o, 3'h7);
        check("vorigin", u_mbp_front_end.vertical_origin_o, 8'h56);
        check("horigin", u_mbp_front_end.horizontal_origin_o, 8'h78);
        check("qp cr", u_mbp_front_end.red_chroma_quantizer_o, 8'h11);
        check("qp cb", u_mbp_front_end.blue_chroma_quantizer_o, 8'h22);
        check("qp y", u_mbp_front_end.luma_quantizer_o, 8'h33);
        check("cbp cr", u_mbp_front_end.red_chroma_coded_pattern_o, 4'h4);
        check("cbp cb", u_mbp_front_end.blue_chroma_coded_pattern_o, 4'h5);
        check("scale cb", u_mbp_front_end.blue_chroma_dc_scale_o, 16'hBEEF);
        check("scale cr", u_mbp_front_end.red_chroma_dc_scale_o, 16'hCAFE);
        check("scale y", u_mbp_front_end.luma_dc_scale_o, 16'hF00D);
        check("resid off", u_mbp_front_end.residual_offset_o, 16'h0140);
        chk_reg(15, 32'h0000_E005);
        // Inter commands: every defined vector code, weighting modes for B then P
        for (i = 0; i < 5; i++) begin
            d = 32'h0000_0002;
            d[22:20] = mvc[i];
            d[7:6] = (i < 3) ? i[1:0] : 2'h3;
            d[5] = (i == 3);
            cmd_w[4] = d;
            run_cmd(4, 1'b0, i >= 3);
            if (i >= 3) d[7:6] = {1'b0, d[5]};
            check("mv count", u_mbp_front_end.mv_count_o, mvn[i]);
            check("wo offset", u_mbp_front_end.weight_offset_o, mvn[i]);
            check("bi weight", u_mbp_front_end.bidirectional_weighting_mode_o, d[7:6]);
            check("one weight", u_mbp_front_end.single_direction_weighting_flag_o, d[5]);
            check("adaptive", u_mbp_front_end.adaptive_frame_field_picture_o, 1'b1);
            check("intra", u_mbp_front_end.intra_macroblock_flag_o, 1'b0);
            check("chroma", u_mbp_front_end.chroma_sampling_format_o, CHROMA_MONO);
            chk_reg(4, d);
        end
        cmd_w[4] = 32'hA00E_0000;
        run_cmd(6, 1'b1, 1'b0);
        check("ref sel", u_mbp_front_end.reference_field_select_o, 4'hA);
        check("mode", u_mbp_front_end.mb_mode_o, MBP_MODE_VC1);
        chk_reg(6, 32'hA00E_0000);
        check("mb done", ndone, 7);
        test_done();
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        fails++;
        test_done();
    end
endmodule : tb_top
